// *** fps_top.v ***
// Fan output source selection matrix with AHB-Lite register access
//
// Operation
// (R1) Fan 1 third select: written temps 0-3
// (R2) Fan 2 first select: local, remote A, B
// (R3) Fan 2 first select: cpu channels 0-3
// (R4) Fan 2 second select: polled devices 0-7
// (R5) Fan 2 third select: written temps 0-3
// (R6) Fan 3 first select: local, remote A, B
// (R7) Fan 3 first select: cpu channels 0-3
// (R8) Fan 3 second select: polled devices 0-7
// (R9) All select registers reset to zero
// (R10) Reserved bits read zero, ignore writes
// (R11) Per-fan combined enable vector to loop
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "fps_map.vh"

module fps_top (
  input  wire                ref_clk,
  input  wire                rst_n,
  input  wire                hsel,
  input  wire [`FPS_AW-1:0]  haddr,
  input  wire [1:0]          htrans,
  input  wire                hwrite,
  input  wire [2:0]          hsize,
  input  wire [31:0]         hwdata,
  input  wire                hready,
  output wire                hreadyout,
  output wire                hresp,
  output wire [31:0]         hrdata,
  output wire                fan_output_1_written_temp0_enable,
  output wire                fan_output_1_written_temp1_enable,
  output wire                fan_output_1_written_temp2_enable,
  output wire                fan_output_1_written_temp3_enable,
  output wire                fan_output_2_local_temp_enable,
  output wire                fan_output_2_remote_diode_a_enable,
  output wire                fan_output_2_remote_diode_b_enable,
  output wire                fan_output_2_cpu_thermal_ch0_enable,
  output wire                fan_output_2_cpu_thermal_ch1_enable,
  output wire                fan_output_2_cpu_thermal_ch2_enable,
  output wire                fan_output_2_cpu_thermal_ch3_enable,
  output wire                fan_output_2_polled_dev0_enable,
  output wire                fan_output_2_polled_dev1_enable,
  output wire                fan_output_2_polled_dev2_enable,
  output wire                fan_output_2_polled_dev3_enable,
  output wire                fan_output_2_polled_dev4_enable,
  output wire                fan_output_2_polled_dev5_enable,
  output wire                fan_output_2_polled_dev6_enable,
  output wire                fan_output_2_polled_dev7_enable,
  output wire                fan_output_2_written_temp0_enable,
  output wire                fan_output_2_written_temp1_enable,
  output wire                fan_output_2_written_temp2_enable,
  output wire                fan_output_2_written_temp3_enable,
  output wire                fan_output_3_local_temp_enable,
  output wire                fan_output_3_remote_diode_a_enable,
  output wire                fan_output_3_remote_diode_b_enable,
  output wire                fan_output_3_cpu_thermal_ch0_enable,
  output wire                fan_output_3_cpu_thermal_ch1_enable,
  output wire                fan_output_3_cpu_thermal_ch2_enable,
  output wire                fan_output_3_cpu_thermal_ch3_enable,
  output wire                fan_output_3_polled_dev0_enable,
  output wire                fan_output_3_polled_dev1_enable,
  output wire                fan_output_3_polled_dev2_enable,
  output wire                fan_output_3_polled_dev3_enable,
  output wire                fan_output_3_polled_dev4_enable,
  output wire                fan_output_3_polled_dev5_enable,
  output wire                fan_output_3_polled_dev6_enable,
  output wire                fan_output_3_polled_dev7_enable,
  output wire [3:0]          fan_output_1_src_en,
  output wire [18:0]         fan_output_2_src_en,
  output wire [14:0]         fan_output_3_src_en,
  output wire [4:0]          fan_output_1_src_count,
  output wire [4:0]          fan_output_2_src_count,
  output wire [4:0]          fan_output_3_src_count,
  output wire                fan_output_1_src_active,
  output wire                fan_output_2_src_active,
  output wire                fan_output_3_src_active
);

  // ****************************************************************************
  // Functions
  // ****************************************************************************
  // Set bits in a byte
  function [4:0] pop8;
    input [7:0] v;
    integer i;
    begin
      pop8 = 5'h00;
      for (i = 0; i < 8; i = i + 1) begin
        pop8 = pop8 + {4'h0, v[i]};
      end
    end
  endfunction

  // Value a register holds after any write now in its data phase
  function [7:0] view;
    input       hit;
    input [7:0] wdata;
    input [7:0] mask;
    input [7:0] cur;
    begin
      view = hit ? (wdata & mask) : cur;
    end
  endfunction

  // ****************************************************************************
  // Bus front end
  // ****************************************************************************
  wire        rd_take;
  wire [7:0]  rd_idx;
  wire        wr_en;
  wire [7:0]  wr_idx;
  reg  [31:0] hrdata_q;
  reg  [31:0] rd_d;

  fps_ahb_front u_front (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .rd_take   (rd_take),
    .rd_idx    (rd_idx),
    .wr_en     (wr_en),
    .wr_idx    (wr_idx)
  );

  // ****************************************************************************
  // Select registers
  // ****************************************************************************
  wire [7:0] f1_push_q;
  wire [7:0] f2_sens_q;
  wire [7:0] f2_poll_q;
  wire [7:0] f2_push_q;
  wire [7:0] f3_sens_q;
  wire [7:0] f3_poll_q;

  // Write strobes, one per register
  wire hit_f1_push = wr_en & (wr_idx == `FPS_IDX_F1_PUSH);
  wire hit_f2_sens = wr_en & (wr_idx == `FPS_IDX_F2_SENSOR);
  wire hit_f2_poll = wr_en & (wr_idx == `FPS_IDX_F2_POLLED);
  wire hit_f2_push = wr_en & (wr_idx == `FPS_IDX_F2_PUSH);
  wire hit_f3_sens = wr_en & (wr_idx == `FPS_IDX_F3_SENSOR);
  wire hit_f3_poll = wr_en & (wr_idx == `FPS_IDX_F3_POLLED);

  // Fan output 1
  fps_sel_reg #(.MASK(`FPS_MASK_PUSH), .RESET(`FPS_SEL_RESET)) u_f1_push ( // R1 R9 R10
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .wr_en   (hit_f1_push),
    .wr_data (hwdata[7:0]),
    .q       (f1_push_q)
  );

  // Fan output 2
  fps_sel_reg #(.MASK(`FPS_MASK_SENSOR), .RESET(`FPS_SEL_RESET)) u_f2_sens ( // R2 R3 R9 R10
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .wr_en   (hit_f2_sens),
    .wr_data (hwdata[7:0]),
    .q       (f2_sens_q)
  );

  fps_sel_reg #(.MASK(`FPS_MASK_POLLED), .RESET(`FPS_SEL_RESET)) u_f2_poll ( // R4 R9
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .wr_en   (hit_f2_poll),
    .wr_data (hwdata[7:0]),
    .q       (f2_poll_q)
  );

  fps_sel_reg #(.MASK(`FPS_MASK_PUSH), .RESET(`FPS_SEL_RESET)) u_f2_push ( // R5 R9 R10
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .wr_en   (hit_f2_push),
    .wr_data (hwdata[7:0]),
    .q       (f2_push_q)
  );

  // Fan output 3
  fps_sel_reg #(.MASK(`FPS_MASK_SENSOR), .RESET(`FPS_SEL_RESET)) u_f3_sens ( // R6 R7 R9 R10
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .wr_en   (hit_f3_sens),
    .wr_data (hwdata[7:0]),
    .q       (f3_sens_q)
  );

  fps_sel_reg #(.MASK(`FPS_MASK_POLLED), .RESET(`FPS_SEL_RESET)) u_f3_poll ( // R8 R9
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .wr_en   (hit_f3_poll),
    .wr_data (hwdata[7:0]),
    .q       (f3_poll_q)
  );

  // ****************************************************************************
  // Forwarded views for back-to-back write then read
  // ****************************************************************************
  wire [7:0] f1_push_v = view(hit_f1_push, hwdata[7:0], `FPS_MASK_PUSH, f1_push_q);
  wire [7:0] f2_sens_v = view(hit_f2_sens, hwdata[7:0], `FPS_MASK_SENSOR, f2_sens_q);
  wire [7:0] f2_poll_v = view(hit_f2_poll, hwdata[7:0], `FPS_MASK_POLLED, f2_poll_q);
  wire [7:0] f2_push_v = view(hit_f2_push, hwdata[7:0], `FPS_MASK_PUSH, f2_push_q);
  wire [7:0] f3_sens_v = view(hit_f3_sens, hwdata[7:0], `FPS_MASK_SENSOR, f3_sens_q);
  wire [7:0] f3_poll_v = view(hit_f3_poll, hwdata[7:0], `FPS_MASK_POLLED, f3_poll_q);

  // ****************************************************************************
  // Source counts and summary
  // ****************************************************************************
  wire [4:0] cnt1_v = pop8(f1_push_v);
  wire [4:0] cnt2_v = pop8(f2_sens_v) + pop8(f2_poll_v) + pop8(f2_push_v);
  wire [4:0] cnt3_v = pop8(f3_sens_v) + pop8(f3_poll_v);
  // Active flags from the counts
  wire [2:0] act_v  = {cnt3_v != 5'h00, cnt2_v != 5'h00, cnt1_v != 5'h00};

  wire [31:0] summary_v = {5'h00, act_v,
                           3'h0, cnt3_v,
                           3'h0, cnt2_v,
                           3'h0, cnt1_v};

  // Loop-side copies, one cycle late
  reg [4:0] cnt1_q;
  reg [4:0] cnt2_q;
  reg [4:0] cnt3_q;
  reg [2:0] act_q;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt1_q <= 5'h00;
      cnt2_q <= 5'h00;
      cnt3_q <= 5'h00;
      act_q  <= 3'h0;
    end else begin
      cnt1_q <= pop8(f1_push_q);
      cnt2_q <= pop8(f2_sens_q) + pop8(f2_poll_q) + pop8(f2_push_q);
      cnt3_q <= pop8(f3_sens_q) + pop8(f3_poll_q);
      act_q  <= {|{f3_sens_q, f3_poll_q},
                 |{f2_sens_q, f2_poll_q, f2_push_q},
                 |f1_push_q};
    end
  end

  // ****************************************************************************
  // Read path
  // ****************************************************************************
  always @* begin
    // Unmapped indices read zero
    case (rd_idx)
      `FPS_IDX_F1_PUSH:   rd_d = {24'h000000, f1_push_v}; // R10
      `FPS_IDX_F2_SENSOR: rd_d = {24'h000000, f2_sens_v}; // R10
      `FPS_IDX_F2_POLLED: rd_d = {24'h000000, f2_poll_v};
      `FPS_IDX_F2_PUSH:   rd_d = {24'h000000, f2_push_v}; // R10
      `FPS_IDX_F3_SENSOR: rd_d = {24'h000000, f3_sens_v}; // R10
      `FPS_IDX_F3_POLLED: rd_d = {24'h000000, f3_poll_v};
      `FPS_IDX_SUMMARY:   rd_d = summary_v;
      default:            rd_d = 32'h00000000;
    endcase
  end

  // Sampled in the address phase, presented in the data phase
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_take) begin
      hrdata_q <= rd_d;
    end
  end

  assign hrdata = hrdata_q;

  // ****************************************************************************
  // Combined vectors to the fan control loop
  // ****************************************************************************
  // Reserved bits left out of the vectors
  assign fan_output_1_src_en = f1_push_q[3:0]; // R11
  assign fan_output_2_src_en = {f2_push_q[3:0], f2_poll_q, f2_sens_q[6:0]}; // R11
  assign fan_output_3_src_en = {f3_poll_q, f3_sens_q[6:0]}; // R11

  // Counts and flags
  assign fan_output_1_src_count  = cnt1_q;
  assign fan_output_2_src_count  = cnt2_q;
  assign fan_output_3_src_count  = cnt3_q;
  assign fan_output_1_src_active = act_q[0];
  assign fan_output_2_src_active = act_q[1];
  assign fan_output_3_src_active = act_q[2];

  // ****************************************************************************
  // Individual enables
  // ****************************************************************************
  // Fan output 1
  assign fan_output_1_written_temp0_enable   = f1_push_q[0]; // R1
  assign fan_output_1_written_temp1_enable   = f1_push_q[1]; // R1
  assign fan_output_1_written_temp2_enable   = f1_push_q[2]; // R1
  assign fan_output_1_written_temp3_enable   = f1_push_q[3]; // R1

  // Fan output 2
  assign fan_output_2_local_temp_enable      = f2_sens_q[`FPS_BIT_LOCAL]; // R2
  assign fan_output_2_remote_diode_a_enable  = f2_sens_q[`FPS_BIT_REMOTE_A]; // R2
  assign fan_output_2_remote_diode_b_enable  = f2_sens_q[`FPS_BIT_REMOTE_B]; // R2
  assign fan_output_2_cpu_thermal_ch0_enable = f2_sens_q[`FPS_BIT_CPU_CH0]; // R3
  assign fan_output_2_cpu_thermal_ch1_enable = f2_sens_q[`FPS_BIT_CPU_CH0+1]; // R3
  assign fan_output_2_cpu_thermal_ch2_enable = f2_sens_q[`FPS_BIT_CPU_CH0+2]; // R3
  assign fan_output_2_cpu_thermal_ch3_enable = f2_sens_q[`FPS_BIT_CPU_CH0+3]; // R3
  assign fan_output_2_polled_dev0_enable     = f2_poll_q[0]; // R4
  assign fan_output_2_polled_dev1_enable     = f2_poll_q[1]; // R4
  assign fan_output_2_polled_dev2_enable     = f2_poll_q[2]; // R4
  assign fan_output_2_polled_dev3_enable     = f2_poll_q[3]; // R4
  assign fan_output_2_polled_dev4_enable     = f2_poll_q[4]; // R4
  assign fan_output_2_polled_dev5_enable     = f2_poll_q[5]; // R4
  assign fan_output_2_polled_dev6_enable     = f2_poll_q[6]; // R4
  assign fan_output_2_polled_dev7_enable     = f2_poll_q[7]; // R4
  assign fan_output_2_written_temp0_enable   = f2_push_q[0]; // R5
  assign fan_output_2_written_temp1_enable   = f2_push_q[1]; // R5
  assign fan_output_2_written_temp2_enable   = f2_push_q[2]; // R5
  assign fan_output_2_written_temp3_enable   = f2_push_q[3]; // R5

  // Fan output 3
  assign fan_output_3_local_temp_enable      = f3_sens_q[`FPS_BIT_LOCAL]; // R6
  assign fan_output_3_remote_diode_a_enable  = f3_sens_q[`FPS_BIT_REMOTE_A]; // R6
  assign fan_output_3_remote_diode_b_enable  = f3_sens_q[`FPS_BIT_REMOTE_B]; // R6
  assign fan_output_3_cpu_thermal_ch0_enable = f3_sens_q[`FPS_BIT_CPU_CH0]; // R7
  assign fan_output_3_cpu_thermal_ch1_enable = f3_sens_q[`FPS_BIT_CPU_CH0+1]; // R7
  assign fan_output_3_cpu_thermal_ch2_enable = f3_sens_q[`FPS_BIT_CPU_CH0+2]; // R7
  assign fan_output_3_cpu_thermal_ch3_enable = f3_sens_q[`FPS_BIT_CPU_CH0+3]; // R7
  assign fan_output_3_polled_dev0_enable     = f3_poll_q[0]; // R8
  assign fan_output_3_polled_dev1_enable     = f3_poll_q[1]; // R8
  assign fan_output_3_polled_dev2_enable     = f3_poll_q[2]; // R8
  assign fan_output_3_polled_dev3_enable     = f3_poll_q[3]; // R8
  assign fan_output_3_polled_dev4_enable     = f3_poll_q[4]; // R8
  assign fan_output_3_polled_dev5_enable     = f3_poll_q[5]; // R8
  assign fan_output_3_polled_dev6_enable     = f3_poll_q[6]; // R8
  assign fan_output_3_polled_dev7_enable     = f3_poll_q[7]; // R8

endmodule // fps_top

`default_nettype wire

// *** fps_map.vh ***
// Register indices, field layouts and reset values of the fan source select block
`ifndef FPS_MAP_VH
`define FPS_MAP_VH

// ****************************************************************************
// Register indices (byte address = index * 4)
// ****************************************************************************
`define FPS_IDX_F1_PUSH     8'h8C
`define FPS_IDX_F2_SENSOR   8'h8D
`define FPS_IDX_F2_POLLED   8'h8E
`define FPS_IDX_F2_PUSH     8'h8F
`define FPS_IDX_F3_SENSOR   8'h90
`define FPS_IDX_F3_POLLED   8'h91
`define FPS_IDX_SUMMARY     8'hC0

// ****************************************************************************
// Writable masks and reset values
// ****************************************************************************
`define FPS_MASK_SENSOR     8'h7F
`define FPS_MASK_POLLED     8'hFF
`define FPS_MASK_PUSH       8'h0F
`define FPS_SEL_RESET       8'h00

// ****************************************************************************
// Field positions of a sensor select register
// ****************************************************************************
`define FPS_BIT_LOCAL       0
`define FPS_BIT_REMOTE_A    1
`define FPS_BIT_REMOTE_B    2
`define FPS_BIT_CPU_CH0     3

// ****************************************************************************
// Summary register layout
// ****************************************************************************
`define FPS_SUM_F1_LSB      0
`define FPS_SUM_F2_LSB      8
`define FPS_SUM_F3_LSB      16
`define FPS_SUM_ACT_LSB     24

// ****************************************************************************
// Bus encodings
// ****************************************************************************
`define FPS_AW              10
`define FPS_HSIZE_WORD      3'h2
`define FPS_HRESP_OKAY      1'b0

`endif

// *** fps_sel_reg.v ***
// One source select register with a writable-bit mask
`timescale 1ns/1ps
`default_nettype none
`include "fps_map.vh"

module fps_sel_reg #(
  parameter [7:0] MASK  = 8'hFF,
  parameter [7:0] RESET = 8'h00
) (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  output wire [7:0] q
);

  reg [7:0] sel_q;

  // Reserved bits never store a one
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= RESET & MASK;
    end else if (wr_en) begin
      sel_q <= wr_data & MASK;
    end
  end

  assign q = sel_q;

endmodule // fps_sel_reg

`default_nettype wire

// *** fps_ahb_front.v ***
// AHB-Lite address and data phase tracking for the select registers
`timescale 1ns/1ps
`default_nettype none
`include "fps_map.vh"

module fps_ahb_front (
  input  wire                ref_clk,
  input  wire                rst_n,
  input  wire                hsel,
  input  wire [`FPS_AW-1:0]  haddr,
  input  wire [1:0]          htrans,
  input  wire                hwrite,
  input  wire [2:0]          hsize,
  input  wire                hready,
  output wire                hreadyout,
  output wire                hresp,
  output wire                rd_take,
  output wire [7:0]          rd_idx,
  output reg                 wr_en,
  output reg  [7:0]          wr_idx
);

  // NONSEQ or SEQ while selected and bus ready
  wire take  = hsel & hready & htrans[1];
  // Narrow writes only reach the low byte lane
  wire lane0 = (hsize == `FPS_HSIZE_WORD) | (haddr[1:0] == 2'h0);

  assign rd_take   = take & ~hwrite;
  assign rd_idx    = haddr[`FPS_AW-1:2];
  assign hreadyout = 1'b1;
  assign hresp     = `FPS_HRESP_OKAY;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_en  <= 1'b0;
      wr_idx <= 8'h00;
    end else begin
      wr_en  <= take & hwrite & lane0;
      wr_idx <= haddr[`FPS_AW-1:2];
    end
  end

endmodule // fps_ahb_front

`default_nettype wire

// *** fps_top_asserts.sv ***
// Concurrent checks of the fan source select block
`timescale 1ns/1ps
`default_nettype none
`include "fps_map.vh"

module fps_top_asserts (
  input wire logic               ref_clk,
  input wire logic               rst_n,
  input wire logic               hsel,
  input wire logic [`FPS_AW-1:0] haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic [31:0]        hwdata,
  input wire logic               hready,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic [31:0]        hrdata,
  input wire logic [3:0]         fan_output_1_src_en,
  input wire logic [18:0]        fan_output_2_src_en,
  input wire logic [14:0]        fan_output_3_src_en,
  input wire logic [4:0]         fan_output_2_src_count,
  input wire logic               fan_output_3_src_active
);
  // ****************************************
  // Helpers
  // ****************************************
  logic [31:0] wd_q;

  // Data phase word, seen one edge later
  always_ff @(posedge ref_clk) wd_q <= hwdata;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_acc(logic [9:0] a, logic w);
    hsel && hready && htrans[1] && (hwrite == w) && (haddr == a);
  endsequence

  // ****************************************
  // Properties
  // ****************************************
  property p_bus_ok;
    hreadyout && !hresp;
  endproperty
  property p_wr_f1;
    s_acc(10'h230, 1'b1) ##1 1'b1 |=> fan_output_1_src_en == wd_q[3:0];
  endproperty
  property p_wr_f2s;
    s_acc(10'h234, 1'b1) ##1 1'b1 |=> fan_output_2_src_en[6:0] == wd_q[6:0];
  endproperty
  property p_wr_f2p;
    s_acc(10'h238, 1'b1) ##1 1'b1 |=> fan_output_2_src_en[14:7] == wd_q[7:0];
  endproperty
  property p_wr_f2w;
    s_acc(10'h23C, 1'b1) ##1 1'b1 |=> fan_output_2_src_en[18:15] == wd_q[3:0];
  endproperty
  property p_wr_f3s;
    s_acc(10'h240, 1'b1) ##1 1'b1 |=> fan_output_3_src_en[6:0] == wd_q[6:0];
  endproperty
  property p_wr_f3p;
    s_acc(10'h244, 1'b1) ##1 1'b1 |=> fan_output_3_src_en[14:7] == wd_q[7:0];
  endproperty
  property p_rd_f2;
    s_acc(10'h234, 1'b0) |=> hrdata == {25'h0, fan_output_2_src_en[6:0]};
  endproperty
  property p_cnt;
    fan_output_2_src_count == 5'($countones($past(fan_output_2_src_en)));
  endproperty
  property p_act;
    fan_output_3_src_active == ($past(fan_output_3_src_en) != 15'h0);
  endproperty
  property p_rst;
    disable iff (1'b0) !rst_n |-> fan_output_1_src_en == 4'h0 && fan_output_2_src_en == 19'h0
      && fan_output_3_src_en == 15'h0 && hrdata == 32'h0;
  endproperty

  a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready or not okay");
  a_wr_f1: assert property (p_wr_f1) else $error("fan 1 written temp enables wrong");
  a_wr_f2s: assert property (p_wr_f2s) else $error("fan 2 sensor enables wrong");
  a_wr_f2p: assert property (p_wr_f2p) else $error("fan 2 polled enables wrong");
  a_wr_f2w: assert property (p_wr_f2w) else $error("fan 2 written temp enables wrong");
  a_wr_f3s: assert property (p_wr_f3s) else $error("fan 3 sensor enables wrong");
  a_wr_f3p: assert property (p_wr_f3p) else $error("fan 3 polled enables wrong");
  a_rd_f2: assert property (p_rd_f2) else $error("fan 2 sensor read back wrong");
  a_cnt: assert property (p_cnt) else $error("fan 2 source count wrong");
  a_act: assert property (p_act) else $error("fan 3 active flag wrong");
  a_rst: assert property (p_rst) else $error("outputs not clear in reset");

  c_wr: cover property (s_acc(10'h234, 1'b1));
  c_sum: cover property (s_acc(10'h300, 1'b0));
  c_act: cover property ($rose(fan_output_3_src_active));
endmodule // fps_top_asserts

bind fps_top fps_top_asserts i_fps_top_asserts (.*);
`default_nettype wire

// *** tb.sv ***
// Self-checking bench of the fan source select block
`timescale 1ns/1ps
`default_nettype none
`include "fps_map.vh"

module tb;
  localparam logic [7:0] MASKS [6] = '{8'h0F, 8'h7F, 8'hFF, 8'h0F, 8'h7F, 8'hFF};
  localparam logic [7:0] PATS [4] = '{8'hFF, 8'hA5, 8'h5A, 8'h3C};
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b1;
  logic        hsel = 1'b0;
  logic [9:0]  haddr = 10'h000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = `FPS_HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  wire         hready;
  wire         hreadyout;
  wire         hresp;
  wire  [31:0] hrdata;
  wire  [3:0]  ind1;
  wire  [18:0] ind2;
  wire  [14:0] ind3;
  wire  [3:0]  fan_output_1_src_en;
  wire  [18:0] fan_output_2_src_en;
  wire  [14:0] fan_output_3_src_en;
  wire  [4:0]  fan_output_1_src_count;
  wire  [4:0]  fan_output_2_src_count;
  wire  [4:0]  fan_output_3_src_count;
  wire         fan_output_1_src_active;
  wire         fan_output_2_src_active;
  wire         fan_output_3_src_active;
  logic [7:0]  sh [6];
  int          bad_count = 0;
  int          tests_run = 0;
  int          cycles = 0;

  assign hready = hreadyout;
  always #2 ref_clk = ~ref_clk;

  fps_top i_fps_top (
    .fan_output_1_written_temp0_enable(ind1[0]), .fan_output_1_written_temp1_enable(ind1[1]),
    .fan_output_1_written_temp2_enable(ind1[2]), .fan_output_1_written_temp3_enable(ind1[3]),
    .fan_output_2_local_temp_enable(ind2[0]), .fan_output_2_remote_diode_a_enable(ind2[1]),
    .fan_output_2_remote_diode_b_enable(ind2[2]), .fan_output_2_cpu_thermal_ch0_enable(ind2[3]),
    .fan_output_2_cpu_thermal_ch1_enable(ind2[4]), .fan_output_2_cpu_thermal_ch2_enable(ind2[5]),
    .fan_output_2_cpu_thermal_ch3_enable(ind2[6]), .fan_output_2_polled_dev0_enable(ind2[7]),
    .fan_output_2_polled_dev1_enable(ind2[8]), .fan_output_2_polled_dev2_enable(ind2[9]),
    .fan_output_2_polled_dev3_enable(ind2[10]), .fan_output_2_polled_dev4_enable(ind2[11]),
    .fan_output_2_polled_dev5_enable(ind2[12]), .fan_output_2_polled_dev6_enable(ind2[13]),
    .fan_output_2_polled_dev7_enable(ind2[14]), .fan_output_2_written_temp0_enable(ind2[15]),
    .fan_output_2_written_temp1_enable(ind2[16]), .fan_output_2_written_temp2_enable(ind2[17]),
    .fan_output_2_written_temp3_enable(ind2[18]), .fan_output_3_local_temp_enable(ind3[0]),
    .fan_output_3_remote_diode_a_enable(ind3[1]), .fan_output_3_remote_diode_b_enable(ind3[2]),
    .fan_output_3_cpu_thermal_ch0_enable(ind3[3]), .fan_output_3_cpu_thermal_ch1_enable(ind3[4]),
    .fan_output_3_cpu_thermal_ch2_enable(ind3[5]), .fan_output_3_cpu_thermal_ch3_enable(ind3[6]),
    .fan_output_3_polled_dev0_enable(ind3[7]), .fan_output_3_polled_dev1_enable(ind3[8]),
    .fan_output_3_polled_dev2_enable(ind3[9]), .fan_output_3_polled_dev3_enable(ind3[10]),
    .fan_output_3_polled_dev4_enable(ind3[11]), .fan_output_3_polled_dev5_enable(ind3[12]),
    .fan_output_3_polled_dev6_enable(ind3[13]), .fan_output_3_polled_dev7_enable(ind3[14]),
    .*
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One single transfer; entered just after a rising edge
  task automatic ahb_go(input logic [9:0] a, input logic w, input logic [31:0] d, input logic s);
    hsel <= s;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
  endtask

  task automatic verify_all;
    logic [18:0] e2;
    logic [14:0] e3;
    logic [4:0]  n1;
    logic [4:0]  n2;
    logic [4:0]  n3;
    e2 = {sh[3][3:0], sh[2], sh[1][6:0]};
    e3 = {sh[5], sh[4][6:0]};
    n1 = 5'($countones(sh[0][3:0]));
    n2 = 5'($countones(e2));
    n3 = 5'($countones(e3));
    for (int i = 0; i < 6; i++) begin
      ahb_go(10'h230 + 10'(4 * i), 1'b0, hwdata, 1'b1);
      check(hrdata, {24'h0, sh[i] & MASKS[i]});
    end
    check(ind1, sh[0][3:0]);
    check(ind2, e2);
    check(ind3, e3);
    check(fan_output_1_src_en, sh[0][3:0]);
    check(fan_output_2_src_en, e2);
    check(fan_output_3_src_en, e3);
    check({fan_output_1_src_count, fan_output_2_src_count, fan_output_3_src_count},
          {n1, n2, n3});
    check({fan_output_1_src_active, fan_output_2_src_active, fan_output_3_src_active},
          {n1 != 5'h0, n2 != 5'h0, n3 != 5'h0});
    ahb_go(10'h300, 1'b0, hwdata, 1'b1);
    check(hrdata, {5'h0, n3 != 5'h0, n2 != 5'h0, n1 != 5'h0, 3'h0, n3, 3'h0, n2, 3'h0, n1});
  endtask

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      $display("[ERR] %0t run did not finish", $time);
      test_done;
    end
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    rst_n <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (sh[i]) sh[i] = 8'h00;
    verify_all;
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < 6; i++) begin
        sh[i] = PATS[p] ^ 8'(i);
        ahb_go(10'h230 + 10'(4 * i), 1'b1, {24'hC3C3C3, sh[i]}, 1'b1);
      end
      verify_all;
    end
    sh[1] = 8'hF0;
    ahb_go(10'h234, 1'b1, 32'hFFFFFFF0, 1'b1);
    ahb_go(10'h234, 1'b0, hwdata, 1'b1);
    check(hrdata, 32'h70);
    // Unmapped, read-only and deselected writes leave the matrix alone
    ahb_go(10'h248, 1'b1, 32'hFF, 1'b1);
    ahb_go(10'h22C, 1'b1, 32'hFF, 1'b1);
    ahb_go(10'h300, 1'b1, 32'hFFFFFFFF, 1'b1);
    ahb_go(10'h230, 1'b1, 32'hFF, 1'b0);
    ahb_go(10'h248, 1'b0, hwdata, 1'b1);
    check(hrdata, 32'h0);
    verify_all;
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check(ind2, 19'h0);
    check({ind1, ind3}, 19'h0);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (sh[i]) sh[i] = 8'h00;
    verify_all;
    test_done;
  end
endmodule // tb

`default_nettype wire
